// ### design/sbr_sys_bus.sv
// Behaviour
// - request line inactive returns mastership
// - one external request at a time
// - internal choice between grant and own request
// - three cases that accept external request
// - external write: one word, interrupt register
// - line fill before dirty writeback
// - store miss merges data into fill
// - uncached load reads, uncached store writes
// - writes allowed during cache maintenance
// - data cycles carry data or end tag
// - read: command, address, valid strobe
// - at most one read pending
// - erroneous response raises bus error
// - after read: release buses, leave master
// - write: command, address, then paced data
// - write sizing single, split or block
// - last write element tagged end
// - repeat address until accept, end after
// - regain mastership two cycles after release
// - reset leaves processor bus master
`timescale 1ns/10ps
module sbr_sys_bus
  import sbr_pkg::*;
#(
  parameter int INTR_W = 5
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic core_req_valid_i,
  input wire sbr_req_s core_req_i,
  input wire logic [LINE_WORDS-1:0][AD_W-1:0] wr_line_i,
  input wire logic write_rate_field_i,
  output logic req_ready_o,
  output logic fill_valid_o,
  output logic [LINE_WORDS-1:0][AD_W-1:0] fill_line_o,
  output logic bus_error_o,
  output logic [INTR_W-1:0] intr_reg_o,
  input wire logic ext_bus_request_n_i,
  input wire logic agent_accept_ok_n_i,
  input wire logic agent_valid_n_i,
  input wire logic [AD_W-1:0] addr_data_bus_i,
  output logic [AD_W-1:0] addr_data_bus_o,
  output logic addr_data_bus_oe_o,
  input wire logic [CMD_W-1:0] command_bus_i,
  output logic [CMD_W-1:0] command_bus_o,
  output logic command_bus_oe_o,
  output logic cpu_valid_n_o,
  output logic cpu_owns_bus_n_o,
  output logic cpu_wants_bus_n_o
);
  logic [SYNC_W-1:0] sync_q;
  logic ext_bus_request_n;
  logic ok;
  logic agent_valid_n;
  logic [CMD_W-1:0] cmd_s;
  logic [AD_W-1:0] ad_s;

  sbr_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i({ext_bus_request_n_i, agent_accept_ok_n_i, agent_valid_n_i,
          command_bus_i, addr_data_bus_i}),
    .q_o(sync_q)
  );

  assign ext_bus_request_n = ~sync_q[SYNC_W-1];
  assign ok = ~sync_q[SYNC_W-2];
  assign agent_valid_n = ~sync_q[SYNC_W-3];
  assign cmd_s = sync_q[AD_W+CMD_W-1:AD_W];
  assign ad_s = sync_q[AD_W-1:0];

  sbr_state_e state, next_state;
  sbr_op_e cur_op, next_cur_op;
  logic [AD_W-1:0] cur_addr, next_cur_addr, vaddr, next_vaddr, store_word, next_store_word;
  logic [CMD_W-1:0] cur_cmd, next_cur_cmd;
  logic cur_wr, next_cur_wr, ok_prev, next_ok_prev, pend_read, next_pend_read;
  logic wb_pend, next_wb_pend, split_pend, next_split_pend, reissue, next_reissue;
  logic gnt_pref, next_gnt_pref, ext_busy, next_ext_busy, rsp_err, next_rsp_err;
  logic [1:0] split_code, next_split_code, gap, next_gap, ret_cnt, next_ret_cnt;
  logic [3:0] nwords, next_nwords;
  logic [2:0] widx, next_widx, wbase, next_wbase;
  logic [LINE_WORDS-1:0][AD_W-1:0] line, next_line;
  logic [INTR_W-1:0] intr, next_intr;
  logic [AD_W-1:0] next_ad;
  logic [CMD_W-1:0] next_cmd;
  logic next_oe, next_valid_n, next_owns_n, next_wants_n, next_ready, next_fill, next_err;

  // launch selection: what the processor would issue next
  logic l_go, l_re, l_take, l_wr;
  logic [AD_W-1:0] l_addr;
  logic [5:0] l_bytes;
  logic [2:0] l_base;
  logic sz_block, sz_split;
  logic [3:0] sz_nwords;
  logic [1:0] sz_code, sz_second;
  logic line_op;

  assign line_op = (core_req_i.op == OP_FILL_I) || (core_req_i.op == OP_LOAD_MISS)
                   || (core_req_i.op == OP_STORE_MISS);

  always_comb begin
    l_go = 1'b0;
    l_re = 1'b0;
    l_take = 1'b0;
    l_wr = 1'b0;
    l_addr = cur_addr;
    l_bytes = 6'h00;
    l_base = 3'h0;
    if (reissue) begin
      l_go = 1'b1;
      l_re = 1'b1;
    end else if (wb_pend) begin
      l_go = 1'b1;
      l_wr = 1'b1;
      l_addr = vaddr;
      l_bytes = LINE_BYTES;
    end else if (split_pend) begin
      l_go = 1'b1;
      l_wr = 1'b1;
      l_addr = cur_addr + 32'h4;
      l_bytes = {4'h0, split_code} + 6'h01;
      l_base = 3'h1;
    end else if (core_req_valid_i && req_ready_o) begin
      l_go = 1'b1;
      l_take = 1'b1;
      // uncached store and cache writeback write, all else reads
      l_wr = (core_req_i.op == OP_UNC_STORE) || (core_req_i.op == OP_CACHE_WB);
      l_addr = line_op ? {core_req_i.addr[AD_W-1:LINE_OFS_BITS], 5'h00} : core_req_i.addr;
      l_bytes = line_op ? LINE_BYTES : core_req_i.nbytes;
    end
  end

  sbr_wsize u_wsize (
    .nbytes_i(l_bytes),
    .block_o(sz_block),
    .split_o(sz_split),
    .nwords_o(sz_nwords),
    .code_o(sz_code),
    .second_o(sz_second)
  );

  logic [2:0] nxt_idx;
  logic last_el;
  assign nxt_idx = widx + 3'h1;
  assign last_el = ({1'b0, widx} == nwords - 4'h1);

  always_comb begin
    next_state = state;
    next_cur_op = cur_op;
    next_cur_addr = cur_addr;
    next_vaddr = vaddr;
    next_store_word = store_word;
    next_cur_cmd = cur_cmd;
    next_cur_wr = cur_wr;
    next_ok_prev = ok;
    next_pend_read = pend_read;
    next_wb_pend = wb_pend;
    next_split_pend = split_pend;
    next_reissue = reissue;
    next_gnt_pref = gnt_pref;
    next_ext_busy = ext_busy;
    next_rsp_err = rsp_err;
    next_split_code = split_code;
    next_gap = gap;
    next_ret_cnt = ret_cnt;
    next_nwords = nwords;
    next_widx = widx;
    next_wbase = wbase;
    next_line = line;
    next_intr = intr;
    next_ad = addr_data_bus_o;
    next_cmd = command_bus_o;
    next_oe = addr_data_bus_oe_o;
    next_valid_n = 1'b1;
    next_owns_n = cpu_owns_bus_n_o;
    next_wants_n = 1'b1;
    next_ready = req_ready_o;
    next_fill = 1'b0;
    next_err = 1'b0;
    case (state)
      S_IDLE: begin
        if (ext_bus_request_n && (!l_go || gnt_pref)) begin
          // grant: bus idle, nothing in flight
          next_gnt_pref = 1'b0;
          next_state = S_EXT;
          next_owns_n = 1'b1;
          next_oe = 1'b0;
          next_wants_n = ~l_go;
        end else if (l_go) begin
          // alternate priority so neither side starves
          next_gnt_pref = 1'b1;
          next_state = S_ISSUE;
          next_valid_n = 1'b0;
          if (l_re) begin
            next_reissue = 1'b0;
            next_ad = cur_addr;
            next_cmd = cur_cmd;
          end else begin
            next_cur_addr = l_addr;
            next_cur_wr = l_wr;
            next_wbase = l_base;
            next_nwords = sz_split ? 4'h1 : sz_nwords;
            next_cur_cmd = (l_wr ? CMD_WRITE : CMD_READ)
                           | (sz_block ? CMD_BLOCK : {3'h0, sz_split ? 2'h3 : sz_code});
            next_split_pend = l_wr && sz_split;
            next_split_code = sz_second;
            if (wb_pend) begin
              next_wb_pend = 1'b0;
            end
            if (l_take) begin
              next_ready = 1'b0;
              next_cur_op = core_req_i.op;
              next_store_word = core_req_i.store_word;
              next_vaddr = core_req_i.victim_addr;
              // reads keep the store word slot in wbase, unused until the fill ends
              if (!l_wr) begin
                next_wbase = core_req_i.addr[LINE_OFS_BITS-1:2];
              end
              // victim written only after the fill read completes
              next_wb_pend = core_req_i.victim_dirty
                             && (core_req_i.op inside {OP_LOAD_MISS, OP_STORE_MISS});
            end
            next_ad = l_addr;
            next_cmd = (l_wr ? CMD_WRITE : CMD_READ)
                       | (sz_block ? CMD_BLOCK : {3'h0, sz_split ? 2'h3 : sz_code});
          end
        end else if (!wb_pend && !split_pend && !reissue) begin
          next_ready = 1'b1;
        end
      end
      S_ISSUE: begin
        if (ext_bus_request_n && !ok_prev && !ok) begin
          // agent asked before accept arrived: yield, retry later
          next_reissue = 1'b1;
          next_state = S_EXT;
          next_owns_n = 1'b1;
          next_oe = 1'b0;
          next_wants_n = 1'b0;
        end else if (ok_prev) begin
          // accept seen one cycle back ends the address cycle
          next_widx = 3'h0;
          if (cur_wr) begin
            next_state = S_WDATA;
            next_gap = 2'h0;
            next_ad = wr_line_i[wbase];
            next_cmd = (nwords == 4'h1) ? DID_EOD : DID_DATA;
            next_valid_n = 1'b0;
          end else begin
            next_pend_read = 1'b1;
            next_rsp_err = 1'b0;
            next_state = S_WAIT_RESP;
            next_owns_n = 1'b1;
            next_oe = 1'b0;
          end
        end else begin
          next_valid_n = 1'b0;
        end
      end
      S_WDATA: begin
        if (!cpu_valid_n_o) begin
          if (last_el) begin
            next_state = S_IDLE;
          end else begin
            next_widx = nxt_idx;
            if (!write_rate_field_i) begin
              next_ad = wr_line_i[3'(wbase + nxt_idx)];
              next_cmd = ({1'b0, nxt_idx} == nwords - 4'h1) ? DID_EOD : DID_DATA;
              next_valid_n = 1'b0;
            end else begin
              next_gap = RATE_GAP;
            end
          end
        end else begin
          if (gap == 2'h1) begin
            next_ad = wr_line_i[3'(wbase + widx)];
            next_cmd = last_el ? DID_EOD : DID_DATA;
            next_valid_n = 1'b0;
          end
          if (gap != 2'h0) begin
            next_gap = gap - 2'h1;
          end
        end
      end
      S_WAIT_RESP, S_EXT: begin
        next_wants_n = ~l_go;
        if (agent_valid_n && ext_busy && cmd_s[DID_FLAG_BIT]) begin
          next_intr = ad_s[INTR_W-1:0];
          next_ext_busy = 1'b0;
        end else if (agent_valid_n && !ext_busy && !cmd_s[DID_FLAG_BIT] && cmd_s[CMD_WRITE_BIT]) begin
          next_ext_busy = 1'b1;
        end else if (state == S_WAIT_RESP && agent_valid_n && !ext_busy && cmd_s[DID_FLAG_BIT]) begin
          // response beats come without arbitration
          next_line[widx] = ad_s;
          next_widx = nxt_idx;
          next_rsp_err = rsp_err | cmd_s[DID_ERR_BIT];
          if (cmd_s[DID_LAST_BIT]) begin
            next_pend_read = 1'b0;
            if (rsp_err || cmd_s[DID_ERR_BIT]) begin
              next_err = 1'b1;
            end else begin
              if (cur_op == OP_STORE_MISS) begin
                next_line[wbase] = store_word;
              end
              next_fill = 1'b1;
            end
            if (ext_bus_request_n) begin
              next_state = S_EXT;
            end else begin
              next_state = S_RETURN;
              next_ret_cnt = RET_LOAD;
            end
          end
        end else if (state == S_EXT && !ext_bus_request_n && !ext_busy) begin
          next_state = S_RETURN;
          next_ret_cnt = RET_LOAD;
        end
      end
      S_RETURN: begin
        next_wants_n = ~l_go;
        if (ret_cnt <= 2'h1) begin
          next_state = S_IDLE;
          next_owns_n = 1'b0;
          next_oe = 1'b1;
        end else begin
          next_ret_cnt = ret_cnt - 2'h1;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      cur_op <= OP_FILL_I;
      cur_addr <= '0;
      vaddr <= '0;
      store_word <= '0;
      cur_cmd <= CMD_READ;
      cur_wr <= 1'b0;
      ok_prev <= 1'b0;
      pend_read <= 1'b0;
      wb_pend <= 1'b0;
      split_pend <= 1'b0;
      reissue <= 1'b0;
      gnt_pref <= 1'b0;
      ext_busy <= 1'b0;
      rsp_err <= 1'b0;
      split_code <= 2'h0;
      gap <= 2'h0;
      ret_cnt <= 2'h0;
      nwords <= 4'h1;
      widx <= 3'h0;
      wbase <= 3'h0;
      line <= '0;
      intr <= '0;
      addr_data_bus_o <= '0;
      command_bus_o <= '0;
      addr_data_bus_oe_o <= 1'b1;
      command_bus_oe_o <= 1'b1;
      cpu_valid_n_o <= 1'b1;
      cpu_owns_bus_n_o <= 1'b0;
      cpu_wants_bus_n_o <= 1'b1;
      req_ready_o <= 1'b0;
      fill_valid_o <= 1'b0;
      bus_error_o <= 1'b0;
    end else begin
      state <= next_state;
      cur_op <= next_cur_op;
      cur_addr <= next_cur_addr;
      vaddr <= next_vaddr;
      store_word <= next_store_word;
      cur_cmd <= next_cur_cmd;
      cur_wr <= next_cur_wr;
      ok_prev <= next_ok_prev;
      pend_read <= next_pend_read;
      wb_pend <= next_wb_pend;
      split_pend <= next_split_pend;
      reissue <= next_reissue;
      gnt_pref <= next_gnt_pref;
      ext_busy <= next_ext_busy;
      rsp_err <= next_rsp_err;
      split_code <= next_split_code;
      gap <= next_gap;
      ret_cnt <= next_ret_cnt;
      nwords <= next_nwords;
      widx <= next_widx;
      wbase <= next_wbase;
      line <= next_line;
      intr <= next_intr;
      addr_data_bus_o <= next_ad;
      command_bus_o <= next_cmd;
      addr_data_bus_oe_o <= next_oe;
      command_bus_oe_o <= next_oe;
      cpu_valid_n_o <= next_valid_n;
      cpu_owns_bus_n_o <= next_owns_n;
      cpu_wants_bus_n_o <= next_wants_n;
      req_ready_o <= next_ready;
      fill_valid_o <= next_fill;
      bus_error_o <= next_err;
    end
  end

  assign fill_line_o = line;
  assign intr_reg_o = intr;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_RELEASE: assert property ((state == S_ISSUE) && ok_prev && !cur_wr
    |=> cpu_owns_bus_n_o && !addr_data_bus_oe_o && cpu_valid_n_o)
    else $error("read issue did not release the bus");
  AST_REPEAT: assert property ((state == S_ISSUE) && !ok_prev && !ext_bus_request_n
    |=> (state == S_ISSUE) && !cpu_valid_n_o && $stable(addr_data_bus_o))
    else $error("address cycle not repeated while accept inactive");
  AST_ONE_READ: assert property ((state == S_ISSUE) && !cur_wr |-> !pend_read)
    else $error("second read issued while one pending");
  AST_REGAIN: assert property ((state == S_EXT) && !ext_bus_request_n && !ext_busy
    |=> cpu_owns_bus_n_o ##1 !cpu_owns_bus_n_o && addr_data_bus_oe_o)
    else $error("mastership not regained two cycles after release");
  AST_EOD: assert property ((state == S_WDATA) && !cpu_valid_n_o
    |-> command_bus_o == (last_el ? DID_EOD : DID_DATA))
    else $error("write element carries wrong identifier");
  AST_INTR: assert property (((state == S_WAIT_RESP) || (state == S_EXT))
    && agent_valid_n && ext_busy && cmd_s[DID_FLAG_BIT]
    |=> intr_reg_o == $past(ad_s[INTR_W-1:0]) && !ext_busy)
    else $error("external write did not reach interrupt register");
  AST_ERR: assert property ((state == S_WAIT_RESP) && agent_valid_n && !ext_busy
    && cmd_s[DID_FLAG_BIT] && cmd_s[DID_LAST_BIT] && cmd_s[DID_ERR_BIT]
    |=> bus_error_o && !fill_valid_o)
    else $error("erroneous response did not raise bus error");
  AST_WB_ORDER: assert property (wb_pend && pend_read |-> state != S_WDATA)
    else $error("dirty writeback before fill read completed");
  AST_ISSUE_END: assert property ((state == S_ISSUE) && ok_prev
    |=> (state != S_ISSUE) ##1 cpu_valid_n_o || cur_wr)
    else $error("issue cycle did not end after accept");

  COV_READ: cover property ((state == S_WAIT_RESP) ##[1:40] fill_valid_o);
  COV_SLOW_WRITE: cover property ((state == S_WDATA) && write_rate_field_i ##[1:40] (state == S_IDLE));
  COV_YIELD: cover property ((state == S_ISSUE) ##1 (state == S_EXT) && reissue);
endmodule

// ### design/sbr_pkg.sv
package sbr_pkg;
  localparam int AD_W = 32;
  localparam int CMD_W = 5;
  localparam int LINE_WORDS = 8;
  localparam logic [5:0] LINE_BYTES = 6'h20;
  localparam int LINE_OFS_BITS = 5;
  // command encodings
  localparam logic [4:0] CMD_READ = 5'h00;
  localparam logic [4:0] CMD_WRITE = 5'h08;
  localparam logic [4:0] CMD_BLOCK = 5'h04;
  localparam int CMD_WRITE_BIT = 3;
  // data identifier encodings
  localparam logic [4:0] DID_DATA = 5'h10;
  localparam logic [4:0] DID_EOD = 5'h18;
  localparam int DID_FLAG_BIT = 4;
  localparam int DID_LAST_BIT = 3;
  localparam int DID_ERR_BIT = 0;
  // timing: clock period in ns, the rest in clock cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int RET_CYCLES = 2;
  localparam logic [1:0] RET_LOAD = 2'(RET_CYCLES - 1);
  localparam logic [1:0] RATE_GAP = 2'h2;
  // sync bundle: req_n, ok_n, valid_n, cmd, ad
  localparam int SYNC_W = 3 + CMD_W + AD_W;
  localparam logic [SYNC_W-1:0] SYNC_RST = 40'he000000000;

  typedef enum logic [2:0] {
    OP_FILL_I,
    OP_LOAD_MISS,
    OP_STORE_MISS,
    OP_UNC_LOAD,
    OP_UNC_STORE,
    OP_CACHE_WB
  } sbr_op_e;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ISSUE,
    S_WDATA,
    S_WAIT_RESP,
    S_EXT,
    S_RETURN
  } sbr_state_e;

  typedef struct packed {
    sbr_op_e op;
    logic [AD_W-1:0] addr;
    logic [5:0] nbytes;
    logic victim_dirty;
    logic [AD_W-1:0] victim_addr;
    logic [AD_W-1:0] store_word;
  } sbr_req_s;
endpackage

// ### design/sbr_sync.sv
`timescale 1ns/10ps
module sbr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stage1 <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule

// ### design/sbr_wsize.sv
`timescale 1ns/10ps
module sbr_wsize (
  input wire logic [5:0] nbytes_i,
  output logic block_o,
  output logic split_o,
  output logic [3:0] nwords_o,
  output logic [1:0] code_o,
  output logic [1:0] second_o
);
  logic blk;
  logic spl;

  always_comb begin
    blk = (nbytes_i >= 6'h08);
    spl = (nbytes_i >= 6'h05) && (nbytes_i <= 6'h07);
    block_o = blk;
    split_o = spl;
    nwords_o = 4'h1;
    code_o = 2'h3;
    second_o = 2'h0;
    if (blk) begin
      nwords_o = 4'((nbytes_i + 6'h03) >> 2);
    end else if (spl) begin
      second_o = 2'(nbytes_i - 6'h05);
    end else begin
      code_o = 2'(nbytes_i - 6'h01);
    end
  end
endmodule

// ### tb/sbr_agent.sv
`timescale 1ns/10ps
module sbr_agent
  import sbr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic err_i,
  input wire logic xw_go_i,
  input wire logic [AD_W-1:0] xw_data_i,
  input wire logic [AD_W-1:0] ad_i,
  input wire logic [CMD_W-1:0] cmd_i,
  input wire logic valid_n_i,
  input wire logic owns_n_i,
  output logic req_n_o,
  output logic ok_n_o,
  output logic valid_n_o,
  output logic drv_o,
  output logic [AD_W-1:0] ad_o,
  output logic [CMD_W-1:0] cmd_o
);
  logic [AD_W-1:0] rd_addr;
  logic pend;
  int st;
  int cnt;
  int beat;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      req_n_o <= 1'b1;
      ok_n_o <= 1'b1;
      valid_n_o <= 1'b1;
      drv_o <= 1'b0;
      ad_o <= '0;
      cmd_o <= '0;
      pend <= 1'b0;
      st <= 0;
      cnt <= 0;
    end else begin
      // slow mode lets an address cycle repeat before flow is granted
      cnt <= (valid_n_i === 1'b0 && cmd_i[DID_FLAG_BIT] === 1'b0) ? cnt + 1 : 0;
      ok_n_o <= slow_i && cnt < 6;
      if (valid_n_i === 1'b0 && cmd_i[4:3] === 2'b00) begin
        pend <= 1'b1;
        rd_addr <= ad_i;
      end
      case (st)
        0: if (xw_go_i) begin
          req_n_o <= 1'b0;
          st <= 4;
        end else if (pend && owns_n_i === 1'b1) begin
          drv_o <= 1'b1;
          beat <= 0;
          st <= 1;
        end
        1: begin
          valid_n_o <= 1'b0;
          cmd_o <= (beat == 7 ? DID_EOD : DID_DATA) | {4'h0, err_i};
          ad_o <= rd_addr + AD_W'(4 * beat);
          beat <= beat + 1;
          if (beat == 7) st <= 2;
        end
        2: begin
          valid_n_o <= 1'b1;
          drv_o <= 1'b0;
          pend <= 1'b0;
          st <= 0;
        end
        4: if (owns_n_i === 1'b1) begin
          drv_o <= 1'b1;
          valid_n_o <= 1'b0;
          cmd_o <= CMD_WRITE;
          ad_o <= '0;
          st <= 5;
        end
        5: begin
          cmd_o <= DID_EOD;
          ad_o <= xw_data_i;
          req_n_o <= 1'b1;
          st <= 2;
        end
        default: st <= 0;
      endcase
    end
  end
endmodule

// ### tb/cpu_system_bus_request_protocol_bench.sv
`timescale 1ns/10ps
module cpu_system_bus_request_protocol_bench;
  import sbr_pkg::*;
  logic mclk_i, rst_n_i, vld, rate, slow, err, xw_go, rdy, fv, be, ad_oe, cmd_oe;
  logic pv_n, own_n, rq_n, ok_n, ev_n, ag_drv, pv, wn;
  sbr_req_s req;
  logic [LINE_WORDS-1:0][AD_W-1:0] wl, fl;
  logic [AD_W-1:0] ad_o, ag_ad, ad_w, flip, xw_d;
  logic [CMD_W-1:0] cmd_o, ag_cmd, cmd_w;
  logic [4:0] intr;
  logic [36:0] bq[$];
  logic [36:0] prev;
  int miscompares, tests_run, nfill, nerr, nraw, nbad, nwant;
  // released lines wander so a stale value cannot pass for a driven one
  assign ad_w = ad_oe ? ad_o : (ag_drv ? ag_ad : flip);
  assign cmd_w = cmd_oe ? cmd_o : (ag_drv ? ag_cmd : flip[4:0]);
  sbr_sys_bus dut_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .core_req_valid_i(vld),
    .core_req_i(req),
    .wr_line_i(wl),
    .write_rate_field_i(rate),
    .req_ready_o(rdy),
    .fill_valid_o(fv),
    .fill_line_o(fl),
    .bus_error_o(be),
    .intr_reg_o(intr),
    .ext_bus_request_n_i(rq_n),
    .agent_accept_ok_n_i(ok_n),
    .agent_valid_n_i(ev_n),
    .addr_data_bus_i(ad_w),
    .addr_data_bus_o(ad_o),
    .addr_data_bus_oe_o(ad_oe),
    .command_bus_i(cmd_w),
    .command_bus_o(cmd_o),
    .command_bus_oe_o(cmd_oe),
    .cpu_valid_n_o(pv_n),
    .cpu_owns_bus_n_o(own_n),
    .cpu_wants_bus_n_o(wn)
  );
  sbr_agent agent_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .slow_i(slow),
    .err_i(err),
    .xw_go_i(xw_go),
    .xw_data_i(xw_d),
    .ad_i(ad_o),
    .cmd_i(cmd_o),
    .valid_n_i(pv_n),
    .owns_n_i(own_n),
    .req_n_o(rq_n),
    .ok_n_o(ok_n),
    .valid_n_o(ev_n),
    .drv_o(ag_drv),
    .ad_o(ag_ad),
    .cmd_o(ag_cmd)
  );
  always @(posedge mclk_i) begin
    flip <= ~flip;
    if (rst_n_i && pv_n === 1'b0 && ad_oe === 1'b1) begin
      if (!(pv && prev === {cmd_o, ad_o})) bq.push_back({cmd_o, ad_o});
      if (cmd_o[DID_FLAG_BIT] === 1'b0) nraw++;
    end
    pv <= (pv_n === 1'b0);
    prev <= {cmd_o, ad_o};
    if (fv === 1'b1) nfill++;
    if (be === 1'b1) nerr++;
    if (wn === 1'b0) nwant++;
    if (own_n === 1'b1 && (ad_oe !== 1'b0 || cmd_oe !== 1'b0)) nbad++;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic beat(input int i, input logic [4:0] c, input logic [31:0] a);
    chk(bq[i], {c, a});
  endtask
  task automatic issue(input sbr_op_e op, input logic [31:0] a, input logic [5:0] n,
                       input logic d, input logic [31:0] sw);
    int k;
    @(posedge mclk_i);
    bq.delete();
    nfill = 0;
    nerr = 0;
    nraw = 0;
    nwant = 0;
    req <= '{op, a, n, d, 32'h5000, sw};
    vld <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    guard(k, 50);
    vld <= 1'b0;
    repeat (3) @(posedge mclk_i);
    k = 0;
    while (rdy !== 1'b1 && k < 500) begin
      @(posedge mclk_i);
      k++;
    end
    guard(k, 500);
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic s_single();
    wl[0] <= 32'h1111_2222;
    issue(OP_UNC_STORE, 32'h1000, 6'h04, 1'b0, '0);
    chk(bq.size(), 2);
    beat(0, 5'h0b, 32'h1000);
    beat(1, DID_EOD, 32'h1111_2222);
  endtask
  task automatic s_split();
    wl[1] <= 32'h3333_4444;
    issue(OP_UNC_STORE, 32'h2000, 6'h06, 1'b0, '0);
    chk(bq.size(), 4);
    beat(0, 5'h0b, 32'h2000);
    beat(1, DID_EOD, 32'h1111_2222);
    beat(2, 5'h09, 32'h2004);
    beat(3, DID_EOD, 32'h3333_4444);
  endtask
  task automatic s_block();
    slow <= 1'b1;
    rate <= 1'b1;
    wl[2] <= 32'h5555_6666;
    // accept must be seen inactive through the sync before the take
    repeat (4) @(posedge mclk_i);
    issue(OP_CACHE_WB, 32'h3000, 6'h0c, 1'b0, '0);
    chk(nraw >= 6, 1'b1);
    chk(bq[0][36:34], 3'b011);
    chk(bq[0][31:0], 32'h3000);
    beat(1, DID_DATA, 32'h1111_2222);
    beat(2, DID_DATA, 32'h3333_4444);
    beat(3, DID_EOD, 32'h5555_6666);
    slow <= 1'b0;
    rate <= 1'b0;
  endtask
  task automatic s_yield();
    slow <= 1'b1;
    xw_d <= 32'h0000_000a;
    repeat (4) @(posedge mclk_i);
    xw_go <= 1'b1;
    fork
      issue(OP_UNC_STORE, 32'h8000, 6'h04, 1'b0, '0);
      begin
        @(posedge mclk_i);
        xw_go <= 1'b0;
      end
    join
    chk(intr, 5'h0a);
    chk(nwant > 0, 1'b1);
    chk(bq.size(), 3);
    beat(0, 5'h0b, 32'h8000);
    beat(1, 5'h0b, 32'h8000);
    beat(2, DID_EOD, 32'h1111_2222);
    slow <= 1'b0;
  endtask
  task automatic s_read();
    for (int i = 0; i < 8; i++)
      wl[i] <= 32'ha0 + i;
    issue(OP_LOAD_MISS, 32'h4010, 6'h20, 1'b1, '0);
    chk(nfill, 1);
    chk(bq.size(), 10);
    chk({bq[0][36:35], bq[0][31:0]}, {2'b00, 32'h4000});
    chk(bq[1][36:34], 3'b011);
    chk(bq[1][31:0], 32'h5000);
    for (int i = 0; i < 8; i++) begin
      chk(fl[i], 32'h4000 + 4 * i);
      beat(i + 2, i == 7 ? DID_EOD : DID_DATA, 32'ha0 + i);
    end
  endtask
  task automatic s_smiss();
    issue(OP_STORE_MISS, 32'h6008, 6'h04, 1'b0, 32'hcafe_0001);
    chk(nfill, 1);
    chk(fl[2], 32'hcafe_0001);
    chk(fl[3], 32'h600c);
    chk(nwant, 0);
  endtask
  task automatic s_err();
    err <= 1'b1;
    issue(OP_FILL_I, 32'h7000, 6'h20, 1'b0, '0);
    chk({nerr, nfill}, {32'd1, 32'd0});
    err <= 1'b0;
  endtask
  task automatic s_xw();
    int k;
    xw_d <= 32'h0000_0015;
    xw_go <= 1'b1;
    @(posedge mclk_i);
    xw_go <= 1'b0;
    k = 0;
    while (intr !== 5'h15 && k < 100) begin
      @(posedge mclk_i);
      k++;
    end
    guard(k, 100);
    k = 0;
    while (own_n !== 1'b0 && k < 100) begin
      @(posedge mclk_i);
      k++;
    end
    guard(k, 100);
    chk(intr, 5'h15);
    chk(ad_oe, 1'b1);
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    vld = 1'b0;
    req = '0;
    wl = '0;
    rate = 1'b0;
    slow = 1'b0;
    err = 1'b0;
    xw_go = 1'b0;
    xw_d = '0;
    flip = '0;
    pv = 1'b0;
    prev = '0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk(own_n, 1'b0);
    chk(pv_n, 1'b1);
    s_single();
    s_split();
    s_block();
    s_yield();
    s_read();
    s_smiss();
    s_err();
    s_xw();
    chk(nbad, 0);
    close_out();
  end
endmodule
